/* File: design/pioc_pkg.sv */
// Package for the parallel I/O controller: register offsets, reset values, line maps.
// Assumes a single system clock and an AHB-Lite register port with 32-bit data.
package pioc_pkg;

   // Register byte offsets
   localparam logic [7:0] off_line_claim       = 8'h00;
   localparam logic [7:0] off_line_release     = 8'h04;
   localparam logic [7:0] off_ownership_status = 8'h08;
   localparam logic [7:0] off_output_enable    = 8'h10;
   localparam logic [7:0] off_output_disable   = 8'h14;
   localparam logic [7:0] off_direction_status = 8'h18;
   localparam logic [7:0] off_filter_enable    = 8'h20;
   localparam logic [7:0] off_filter_disable   = 8'h24;
   localparam logic [7:0] off_filter_status    = 8'h28;
   localparam logic [7:0] off_set_level        = 8'h30;
   localparam logic [7:0] off_clear_level      = 8'h34;
   localparam logic [7:0] off_output_level     = 8'h38;
   localparam logic [7:0] off_pin_level        = 8'h3c;
   localparam logic [7:0] off_irq_enable       = 8'h40;
   localparam logic [7:0] off_irq_disable      = 8'h44;
   localparam logic [7:0] off_irq_mask         = 8'h48;
   localparam logic [7:0] off_change_status    = 8'h4c;
   localparam logic [7:0] off_open_drain_en    = 8'h50;
   localparam logic [7:0] off_open_drain_dis   = 8'h54;
   localparam logic [7:0] off_open_drain_stat  = 8'h58;

   // Port geometry and per-line maps for the first port
   localparam int          data_width       = 32;
   localparam int          settle_cycles    = 5;  // Edges from a pin to the previous sample
   localparam logic [31:0] first_impl_mask  = 32'h3fff_ffff;
   localparam logic [31:0] first_mux_mask   = 32'h3fff_ffff;
   localparam logic [31:0] first_off_value  = 32'h0400_0000;
   // Second port: lines 0..27, multiplexed lines 3,4,6,7,18..27 (line 5 dedicated)
   localparam logic [31:0] second_impl_mask = 32'h0fff_ffff;
   localparam logic [31:0] second_mux_mask  = 32'h0ffc_00d8;
   localparam logic [31:0] second_off_value = 32'h0000_0000;

   // Reset values
   localparam logic [31:0] zero_word = 32'h0000_0000;

   // AHB-Lite transfer codes
   localparam logic [1:0] htrans_nonseq = 2'b10;
   localparam logic [2:0] hsize_word    = 3'b010;

   // Captured address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] offset;
   } pioc_addr_phase_type;

endpackage : pioc_pkg

/* File: design/pioc_port.sv */
// One parallel I/O controller instance: registers, pin muxing, filter, change detect.
// Assumes an AHB-Lite master on hclk, pins outside the clock domain, peripherals on hclk.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Reset: controller owns lines, drivers off
// - Claim/release writes set owner; status reads it
// - Dedicated lines ignore claim/release, read 1
// - Owned lines feed peripheral its default level
// - Output enable/disable writes set direction
// - Direction steers pad only under controller
// - Set/clear writes program output level
// - Owned non-output lines are not driven
// - Peripheral owner supplies pad value and enable
// - Pin level register shows real pin level
// - Filter enable/disable writes; status reads
// - Filter acts for peripheral and change detect
// - Irq enable/disable writes set mask bits
// - Any level change sets change status
// - Interrupt high while masked change pending
// - Change status clears on read, keeps new
// - 32-bit registers; missing lines ignored, zero
// - Open-drain lines drive low only
// - Open-drain enable/disable writes; status reads
// - Two identical instances, own registers, irq
// - First port select-zero default is one
// - Default level fed while controller owns
module pioc_port #(
   parameter logic [31:0] impl_mask = pioc_pkg::first_impl_mask,  // Implemented lines
   parameter logic [31:0] mux_mask  = pioc_pkg::first_mux_mask,   // Lines with a peripheral
   parameter logic [31:0] off_value = pioc_pkg::first_off_value   // Peripheral default levels
) (
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic       [31:0] hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire  logic [31:0] pin_in,
   output logic       [31:0] pin_out,
   output logic       [31:0] pin_oe_n,
   input  wire  logic [31:0] periph_out,
   input  wire  logic [31:0] periph_oe,
   output logic       [31:0] periph_in,
   output logic              irq
);

   // Parameter check: masks must stay within the implemented lines
   if ((mux_mask & ~impl_mask) != pioc_pkg::zero_word) begin : g_bad_mask
      $error("mux_mask names unimplemented lines");
   end

   // Returns the word with unimplemented line bits forced to zero
   function automatic logic [31:0] keep_lines(input logic [31:0] w);
      keep_lines = w & impl_mask;
   endfunction : keep_lines

   pioc_pkg::pioc_addr_phase_type aphase;  // Captured address phase
   logic [31:0] owned;          // 1 = controller owns line
   logic [31:0] dir_out;        // 1 = line is output
   logic [31:0] level;          // Programmed output level
   logic [31:0] filt_en;        // Glitch filter enabled
   logic [31:0] irq_mask;       // Change interrupt mask
   logic [31:0] change;         // Sticky change status
   logic [31:0] open_drain;     // Multi-driver mode
   logic [31:0] sync1;          // Pin synchroniser stage 1
   logic [31:0] sync2;          // Pin synchroniser stage 2
   logic [31:0] sync3;          // Pin synchroniser stage 3
   logic [31:0] clean;          // Accepted pin level
   logic [31:0] filt;           // Filtered pin level
   logic [31:0] filt_prev;      // Previous effective sample
   logic [31:0] next_sel;       // Effective sample per line
   logic [31:0] wdata;          // Write data, implemented lines only
   logic [31:0] next_rdata;     // Read mux
   logic        wr;             // Data-phase write strobe
   logic        rd_now;         // Read wait cycle, where read data is fetched
   logic        rd_change;      // Read of change status in its wait cycle
   logic [pioc_pkg::settle_cycles-1:0] warm;  // Fills with ones while pin samples settle

   // Address phase capture; only whole-word single transfers are expected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aphase <= '0;
      end else if (hready) begin
         aphase.valid  <= hsel && (htrans == pioc_pkg::htrans_nonseq)
                          && (hsize == pioc_pkg::hsize_word);
         aphase.write  <= hwrite;
         aphase.offset <= haddr[7:0];
      end
   end

   // Reads take one wait cycle so read data leaves a flip-flop; writes take none; always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= !(hready && hsel && (htrans == pioc_pkg::htrans_nonseq) && !hwrite);
         hresp     <= 1'b0;
      end
   end

   assign wr        = aphase.valid && aphase.write;
   assign rd_now    = aphase.valid && !aphase.write && !hreadyout;
   assign rd_change = rd_now && (aphase.offset == pioc_pkg::off_change_status);
   assign wdata     = keep_lines(hwdata);

   // Ownership; dedicated lines stay with the controller
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         owned <= impl_mask;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_line_claim) begin
            owned <= owned | (wdata & mux_mask);
         end else if (aphase.offset == pioc_pkg::off_line_release) begin
            owned <= owned & ~(wdata & mux_mask);
         end
      end
   end

   // Direction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_out <= pioc_pkg::zero_word;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_output_enable) begin
            dir_out <= dir_out | wdata;
         end else if (aphase.offset == pioc_pkg::off_output_disable) begin
            dir_out <= dir_out & ~wdata;
         end
      end
   end

   // Output level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level <= pioc_pkg::zero_word;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_set_level) begin
            level <= level | wdata;
         end else if (aphase.offset == pioc_pkg::off_clear_level) begin
            level <= level & ~wdata;
         end
      end
   end

   // Glitch filter enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_en <= pioc_pkg::zero_word;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_filter_enable) begin
            filt_en <= filt_en | wdata;
         end else if (aphase.offset == pioc_pkg::off_filter_disable) begin
            filt_en <= filt_en & ~wdata;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= pioc_pkg::zero_word;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_irq_enable) begin
            irq_mask <= irq_mask | wdata;
         end else if (aphase.offset == pioc_pkg::off_irq_disable) begin
            irq_mask <= irq_mask & ~wdata;
         end
      end
   end

   // Open-drain mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         open_drain <= pioc_pkg::zero_word;
      end else if (wr) begin
         if (aphase.offset == pioc_pkg::off_open_drain_en) begin
            open_drain <= open_drain | wdata;
         end else if (aphase.offset == pioc_pkg::off_open_drain_dis) begin
            open_drain <= open_drain & ~wdata;
         end
      end
   end

   // Three-stage pin synchroniser; a level is accepted once stages 2 and 3 agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= pioc_pkg::zero_word;
         sync2 <= pioc_pkg::zero_word;
         sync3 <= pioc_pkg::zero_word;
         clean <= pioc_pkg::zero_word;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
         clean <= (sync2 & sync3) | (clean & (sync2 | sync3));
      end
   end

   // Glitch filter: a change must hold three cycles before it passes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt <= pioc_pkg::zero_word;
      end else begin
         filt <= (clean & sync3 & sync2) | (filt & (clean | sync3 | sync2));
      end
   end

   assign next_sel = keep_lines((filt_en & filt) | (~filt_en & clean));

   // Change detection with clear-on-read; a new change wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_prev <= pioc_pkg::zero_word;
         change    <= pioc_pkg::zero_word;
         warm      <= '0;
      end else begin
         filt_prev <= next_sel;
         warm      <= {warm[pioc_pkg::settle_cycles-2:0], 1'b1};
         if (!warm[pioc_pkg::settle_cycles-1]) begin
            change <= pioc_pkg::zero_word;  // Pipeline still filling: no false edge after reset
         end else if (rd_change) begin
            change <= next_sel ^ filt_prev;
         end else begin
            change <= change | (next_sel ^ filt_prev);
         end
      end
   end

   // Interrupt output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(change & irq_mask);
      end
   end

   // Pad drive; open drain releases instead of driving high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out  <= pioc_pkg::zero_word;
         pin_oe_n <= ~pioc_pkg::zero_word;
      end else begin
         for (int i = 0; i < pioc_pkg::data_width; i++) begin
            logic v;
            logic e;
            v = 1'b0;
            e = 1'b0;
            if (!impl_mask[i]) begin
               e = 1'b0;
            end else if (owned[i]) begin
               v = level[i];
               e = dir_out[i];
            end else begin
               v = periph_out[i];
               e = periph_oe[i];
            end
            if (open_drain[i] && v) begin
               e = 1'b0;
            end
            pin_out[i]  <= v;
            pin_oe_n[i] <= !e;
         end
      end
   end

   // Peripheral inputs: default level while the controller owns the line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_in <= pioc_pkg::zero_word;
      end else begin
         periph_in <= keep_lines((owned & off_value) | (~owned & next_sel));
      end
   end

   // Read multiplexer
   always_comb begin
      case (aphase.offset)
         pioc_pkg::off_ownership_status: next_rdata = owned | (impl_mask & ~mux_mask);
         pioc_pkg::off_direction_status: next_rdata = dir_out;
         pioc_pkg::off_filter_status:    next_rdata = filt_en;
         pioc_pkg::off_output_level:     next_rdata = level;
         pioc_pkg::off_pin_level:        next_rdata = keep_lines(clean);
         pioc_pkg::off_irq_mask:         next_rdata = irq_mask;
         pioc_pkg::off_change_status:    next_rdata = change;
         pioc_pkg::off_open_drain_stat:  next_rdata = open_drain;
         default:                        next_rdata = pioc_pkg::zero_word;
      endcase
   end

   // Read data register: loaded in the wait cycle, zero outside the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= pioc_pkg::zero_word;
      end else begin
         hrdata <= rd_now ? next_rdata : pioc_pkg::zero_word;
      end
   end

endmodule : pioc_port

// Top: two identical controllers sharing the 58 lines
module pioc_top (
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   input  wire  logic        hsel_first,
   input  wire  logic        hsel_second,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic       [31:0] hrdata_first,
   output logic              hreadyout_first,
   output logic              hresp_first,
   output logic       [31:0] hrdata_second,
   output logic              hreadyout_second,
   output logic              hresp_second,
   input  wire  logic [31:0] pin_in_first,
   output logic       [31:0] pin_out_first,
   output logic       [31:0] pin_oe_n_first,
   input  wire  logic [31:0] periph_out_first,
   input  wire  logic [31:0] periph_oe_first,
   output logic       [31:0] periph_in_first,
   output logic              irq_first,
   input  wire  logic [31:0] pin_in_second,
   output logic       [31:0] pin_out_second,
   output logic       [31:0] pin_oe_n_second,
   input  wire  logic [31:0] periph_out_second,
   input  wire  logic [31:0] periph_oe_second,
   output logic       [31:0] periph_in_second,
   output logic              irq_second
);

   // First port: lines 0..29, select-zero default high
   pioc_port #(.impl_mask(pioc_pkg::first_impl_mask), .mux_mask(pioc_pkg::first_mux_mask),
      .off_value(pioc_pkg::first_off_value)) u_port_first (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel_first), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata_first), .hreadyout(hreadyout_first), .hresp(hresp_first),
      .pin_in(pin_in_first), .pin_out(pin_out_first), .pin_oe_n(pin_oe_n_first),
      .periph_out(periph_out_first), .periph_oe(periph_oe_first),
      .periph_in(periph_in_first), .irq(irq_first));

   // Second port: lines 0..27
   pioc_port #(.impl_mask(pioc_pkg::second_impl_mask), .mux_mask(pioc_pkg::second_mux_mask),
      .off_value(pioc_pkg::second_off_value)) u_port_second (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel_second), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata_second), .hreadyout(hreadyout_second), .hresp(hresp_second),
      .pin_in(pin_in_second), .pin_out(pin_out_second), .pin_oe_n(pin_oe_n_second),
      .periph_out(periph_out_second), .periph_oe(periph_oe_second),
      .periph_in(periph_in_second), .irq(irq_second));

endmodule : pioc_top

`default_nettype wire

/* File: bench/pioc_pins_model.sv */
// Pad model for one port: pull-up on every pad and an external low driver per line.
// Assumes pin_oe_n low means the controller drives the pad.
`timescale 1ns/10ps
`default_nettype none
module pioc_pins_model (
   input  wire logic [31:0] pin_out,   // Controller pad value
   input  wire logic [31:0] pin_oe_n,  // Controller drive, low active
   input  wire logic [31:0] ext_n,     // External low driver, low active
   output logic      [31:0] pin_in     // Resolved pad level
);
   // Undriven pads float up, any low driver wins
   assign pin_in = (pin_oe_n | pin_out) & ext_n;
endmodule : pioc_pins_model
`default_nettype wire

/* File: bench/pioc_top_sva.sv */
// Checker for the two-port controller top, watching its ports only.
// Assumes word transfers and a bus ready shared by both ports.
`timescale 1ns/10ps
`default_nettype none
module pioc_top_sva (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel_first,
   input wire logic        hsel_second,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata_first,
   input wire logic        hreadyout_first,
   input wire logic        hresp_first,
   input wire logic        hreadyout_second,
   input wire logic        hresp_second,
   input wire logic [31:0] pin_out_first,
   input wire logic [31:0] pin_oe_n_first,
   input wire logic [31:0] pin_oe_n_second,
   input wire logic [31:0] periph_out_first,
   input wire logic [31:0] periph_oe_first,
   input wire logic        irq_first,
   input wire logic        irq_second
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Requests taken per port
   wire acc_f = hsel_first && hready && htrans == 2'b10;
   wire acc_s = hsel_second && hready && htrans == 2'b10;
   wire rd_f  = acc_f && !hwrite;
   wire wr_f  = acc_f && hwrite;
   // Pads released when reset ends
   property p_reset_hiz;
      $rose(hresetn) |-> pin_oe_n_first == 32'hffff_ffff && pin_oe_n_second == 32'hffff_ffff;
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("pad driven after reset");
   // Missing lines are never driven
   property p_unimpl;
      pin_oe_n_first[31:30] == 2'b11 && pin_oe_n_second[31:28] == 4'hf;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("missing line driven");
   // Drive changes only after a write or a peripheral move
   property p_oe_cause;
      !$stable(pin_oe_n_first) |-> $past(wr_f, 3) ||
         $past(periph_oe_first) != $past(periph_oe_first, 2) ||
         $past(periph_out_first) != $past(periph_out_first, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("pad enable moved alone");
   // Pad value changes only after a write or a peripheral move
   property p_out_cause;
      !$stable(pin_out_first) |-> $past(wr_f, 3) ||
         $past(periph_out_first) != $past(periph_out_first, 2);
   endproperty
   a_out_cause: assert property (p_out_cause) else $error("pad value moved alone");
   // Read data is zero outside a read data phase, which follows one wait cycle
   property p_rdata_idle;
      !$past(rd_f, 2) |-> hrdata_first == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside phase");
   // A read wait cycle lasts a single cycle on either port
   property p_ready_ok;
      (!hreadyout_first || !hreadyout_second) |=> hreadyout_first && hreadyout_second;
   endproperty
   a_ready_ok: assert property (p_ready_ok) else $error("wait cycle too long");
   // Both ports always answer OKAY
   property p_resp_ok;
      !hresp_first && !hresp_second;
   endproperty
   a_resp_ok: assert property (p_resp_ok) else $error("error response seen");
   // Interrupt drops only after an access to its port
   property p_irq_fall;
      $fell(irq_first) |-> $past(acc_f, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("first irq dropped alone");
   property p_irq2_fall;
      $fell(irq_second) |-> $past(acc_s, 3);
   endproperty
   a_irq2_fall: assert property (p_irq2_fall) else $error("second irq dropped alone");
endmodule : pioc_top_sva
`default_nettype wire

/* File: bench/tb_pioc_top.sv */
// Testbench for the two-port controller: AHB-Lite master, pad models, peripheral drive.
// Assumes slaves that may insert wait states and pull-ups on every pad.
`timescale 1ns/10ps
`default_nettype none
module tb_pioc_top;
   logic        hclk, hresetn, hsel_first, hsel_second, hwrite, dp_rd, dp_port;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, rd_q, hrdata_first, hrdata_second;
   logic        hreadyout_first, hresp_first, hreadyout_second, hresp_second;
   logic [31:0] pin_in_first, pin_out_first, pin_oe_n_first, periph_out_first;
   logic [31:0] periph_oe_first, periph_in_first, ext_n_first, ext_n_second;
   logic [31:0] pin_in_second, pin_out_second, pin_oe_n_second, periph_out_second;
   logic [31:0] periph_oe_second, periph_in_second;
   logic        irq_first, irq_second;
   wire         hready = hreadyout_first & hreadyout_second;  // Shared bus ready
   int          n_mismatch = 0, compares = 0, seed = 32'h01b7908f;
   logic [31:0] expq[$];                   // Expected read data, oldest first
   logic [31:0] r, a, b, pe, po, own, en, val, im;
   pioc_top dut_u (.*);
   pioc_pins_model pad_first (.pin_out(pin_out_first), .pin_oe_n(pin_oe_n_first),
      .ext_n(ext_n_first), .pin_in(pin_in_first));
   pioc_pins_model pad_second (.pin_out(pin_out_second), .pin_oe_n(pin_oe_n_second),
      .ext_n(ext_n_second), .pin_in(pin_in_second));
   // Free running 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Counts, verdict, end of run
   task automatic report_and_stop;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // Word compare, unknowns never match
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   // Bounded wait for ready high at a rising edge
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : wait_ready
   // One single word transfer; a read is judged only if an expectation was noted
   task automatic bus(input logic p, input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge hclk);
      hsel_first  <= !p;
      hsel_second <= p;
      haddr       <= {24'h000000, ad};
      htrans      <= 2'b10;
      hwrite      <= w;
      wait_ready();
      htrans      <= 2'b00;
      hsel_first  <= 1'b0;
      hsel_second <= 1'b0;
      hwdata      <= d;
      dp_rd       <= !w && expq.size() != 0;
      dp_port     <= p;
      wait_ready();
      dp_rd       <= 1'b0;
   endtask : bus
   task automatic rd(input logic p, input logic [7:0] ad, input logic [31:0] e);
      expq.push_back(e);
      bus(p, 1'b0, ad, 32'h0000_0000);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(negedge hclk);
   endtask : idle
   // Read data held mid cycle, judged at the data phase edge
   always @(negedge hclk) rd_q <= dp_port ? hrdata_second : hrdata_first;
   always @(posedge hclk) begin
      if (dp_rd === 1'b1 && hready === 1'b1 && expq.size() != 0) begin
         chk("read data", expq.pop_front(), rd_q);
      end
   end
   // Main sequence
   initial begin
      {hresetn, hsel_first, hsel_second, hwrite, dp_rd, dp_port} = 6'h00;
      {htrans, haddr, hwdata, periph_out_first, periph_oe_first} = '0;
      {periph_out_second, periph_oe_second} = '0;
      hsize = 3'b010;
      ext_n_first = 32'hffff_ffff;
      ext_n_second = 32'hffff_ffff;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(0, 8'h08, pioc_pkg::first_impl_mask);
      rd(1, 8'h08, pioc_pkg::second_impl_mask);
      foreach (im[i]) begin
         if (i < 6) rd(i[0], 8'h18 + 8'h10 * i[7:0], 32'h0000_0000);
      end
      rd(0, 8'h0c, 32'h0000_0000);
      rd(0, 8'h3c, pioc_pkg::first_impl_mask);
      // Dedicated lines ignore release; claim takes back multiplexed line 3
      bus(1, 1'b1, 8'h04, 32'hffff_ffff);
      im = pioc_pkg::second_impl_mask & ~pioc_pkg::second_mux_mask;
      rd(1, 8'h08, im);
      bus(1, 1'b1, 8'h00, 32'h0000_0008);
      rd(1, 8'h08, im | 32'h0000_0008);
      bus(1, 1'b1, 8'h00, 32'hffff_ffff);
      // First port: random ownership, direction, level, peripheral drive, open drain
      bus(0, 1'b1, 8'h40, 32'h0000_0001);
      im = pioc_pkg::first_impl_mask;
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         a = $random(seed);
         b = $random(seed);
         pe = $random(seed);
         po = $random(seed);
         @(posedge hclk);
         periph_oe_first  <= pe;
         periph_out_first <= po;
         bus(0, 1'b1, 8'h00, 32'hffff_ffff);
         bus(0, 1'b1, 8'h04, r);
         bus(0, 1'b1, 8'h10, a);
         bus(0, 1'b1, 8'h14, ~a);
         bus(0, 1'b1, 8'h30, b);
         bus(0, 1'b1, 8'h34, ~b);
         bus(0, 1'b1, k[0] ? 8'h50 : 8'h54, 32'hffff_ffff);
         own = im & ~r;
         val = (own & b) | (~own & po);
         en = ((own & a) | (~own & pe & im)) & ~({32{k[0]}} & val);
         rd(0, 8'h08, own);
         rd(0, 8'h18, a & im);
         rd(0, 8'h38, b & im);
         rd(0, 8'h58, k[0] ? im : 32'h0000_0000);
         rd(0, 8'h3c, (~en | val) & im);
         chk("pad enable", ~en, pin_oe_n_first);
         chk("pad value", val & en, pin_out_first & en);
         chk("periph in", (own & pioc_pkg::first_off_value) | (~own & (~en | val) & im),
            periph_in_first);
         bus(0, 1'b0, 8'h4c, 32'h0000_0000);
      end
      // Second port: change status, mask, filter
      bus(1, 1'b0, 8'h4c, 32'h0000_0000);
      bus(1, 1'b1, 8'h40, 32'h0000_0001);
      bus(1, 1'b1, 8'h20, 32'h0000_0004);
      rd(1, 8'h48, 32'h0000_0001);
      rd(1, 8'h28, 32'h0000_0004);
      @(posedge hclk);
      ext_n_second <= 32'hffff_fffa;
      idle(12);
      chk("irq", 32'h1, {31'h0, irq_second});
      rd(1, 8'h4c, 32'h0000_0005);
      idle(2);
      chk("irq", 32'h0, {31'h0, irq_second});
      rd(1, 8'h4c, 32'h0000_0000);
      @(posedge hclk);
      ext_n_second <= 32'hffff_ffff;
      idle(12);
      chk("irq", 32'h1, {31'h0, irq_second});
      bus(1, 1'b1, 8'h44, 32'h0000_0001);
      idle(2);
      chk("irq", 32'h0, {31'h0, irq_second});
      rd(1, 8'h48, 32'h0000_0000);
      rd(1, 8'h4c, 32'h0000_0005);
      bus(1, 1'b1, 8'h24, 32'h0000_0004);
      rd(1, 8'h28, 32'h0000_0000);
      report_and_stop();
   end
endmodule : tb_pioc_top
bind pioc_top pioc_top_sva chk_u (.*);
`default_nettype wire
